// ==== cgc_clock_ctrl.sv ====
// clock generator control: oscillator, measurement, pll setup, clock selection
// assumes source clocks are one-cycle enables synchronous to hclk
//
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module cgc_clock_ctrl #(
  parameter int NUM_PROG = 3
) (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [31:0]              hrdata,
  input  wire logic                slow_clk_tick,
  input  wire logic                osc_clk_tick,
  input  wire logic                crystal_in_pin,
  input  wire logic                pll_clk_tick,
  output logic                     osc_enable,
  output logic                     pll_in_tick,
  output logic [10:0]              pll_factor_out,
  output logic [1:0]               pll_range,
  output logic                     usb_clk_tick,
  output logic                     sys_clk_tick,
  output logic [NUM_PROG-1:0]      prog_clock_out,
  output logic [31:0]              irq_enabled
);

  typedef struct packed {
    logic                      ext_mode;
    logic                      osc_on;
    logic [7:0]                startup_wait;
    cgc_pkg::cgc_osc_t         ost;
    logic [10:0]               osc_cnt;
    logic                      stable;
    cgc_pkg::cgc_meas_t        mst;
    logic [4:0]                win_cnt;
    logic [15:0]               mcnt;
    logic [15:0]               main_freq_count;
    logic                      freq_valid;
    logic [7:0]                pll_div;
    logic [5:0]                lock_wait;
    logic [1:0]                out_range;
    logic [10:0]               pll_factor;
    logic [1:0]                usb_ratio;
    logic [5:0]                lock_cnt;
    logic                      locked;
    logic [7:0]                div_cnt;
    logic                      pll_in_tick;
    logic [1:0]                usb_cnt;
    logic                      usb_tick;
    logic [4:0]                sys_sel;
    logic [NUM_PROG-1:0][4:0]  pck_sel;
    logic [31:0]               irq_en;
    logic                      wr_pend;
    logic [7:0]                addr_q;
    logic [31:0]               rdata;
    logic                      rdy;
  } cgc_state_t;

  localparam cgc_state_t S_RST = '{
    ost: cgc_pkg::OSC_OFF, mst: cgc_pkg::MEAS_IDLE,
    lock_wait: cgc_pkg::LOCK_WAIT_RST, lock_cnt: cgc_pkg::LOCK_WAIT_RST,
    rdy: 1'b1, default: '0};

  cgc_state_t           s;
  cgc_state_t           next_s;
  logic                 accept;
  logic                 wr_osc;
  logic                 wr_pll;
  logic                 wr_sys;
  logic                 wr_ien;
  logic                 wr_idis;
  logic [NUM_PROG-1:0]  wr_pck;
  logic                 main_tick;
  logic                 pll_tick;
  logic                 sys_rdy;
  logic [NUM_PROG-1:0]  pck_rdy;
  logic [31:0]          rd_val;
  logic [31:0]          status;
  logic [1:0]           usb_lim;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  // zero wait states, so address phase is taken whenever hready is high
  assign accept  = hsel && htrans[1] && hready;
  assign wr_osc  = s.wr_pend && s.addr_q == cgc_pkg::OFS_OSC;
  assign wr_pll  = s.wr_pend && s.addr_q == cgc_pkg::OFS_PLL;
  assign wr_sys  = s.wr_pend && s.addr_q == cgc_pkg::OFS_SYS;
  assign wr_ien  = s.wr_pend && s.addr_q == cgc_pkg::OFS_IEN;
  assign wr_idis = s.wr_pend && s.addr_q == cgc_pkg::OFS_IDIS;
  assign wr_pck[0] = s.wr_pend && s.addr_q == cgc_pkg::OFS_PCK0;
  assign wr_pck[1] = s.wr_pend && s.addr_q == cgc_pkg::OFS_PCK1;
  assign wr_pck[2] = s.wr_pend && s.addr_q == cgc_pkg::OFS_PCK2;

  // ****************************************************************
  // clock sources
  // ****************************************************************
  // bypass takes the pin clock directly
  assign main_tick = s.stable && (s.ext_mode ? crystal_in_pin : osc_clk_tick);
  // zero factor leaves the pll dead
  assign pll_tick  = pll_clk_tick && s.pll_factor != 11'h000;
  assign usb_lim   = 2'((3'h1 << s.usb_ratio) - 3'h1);

  always_comb begin
    status = '0;
    status[cgc_pkg::ST_STABLE]  = s.stable;
    status[cgc_pkg::ST_LOCK]    = s.locked;
    status[cgc_pkg::ST_SYS_RDY] = sys_rdy;
    status[cgc_pkg::ST_PCK_LSB +: NUM_PROG] = pck_rdy;
  end

  // read mux; write-only and unmapped offsets read as zero
  always_comb begin
    rd_val = '0;
    unique case (haddr[7:0])
      cgc_pkg::OFS_OSC: begin
        rd_val[cgc_pkg::OSC_ON_BIT]       = s.osc_on;
        rd_val[cgc_pkg::EXT_MODE_BIT]     = s.ext_mode;
        rd_val[cgc_pkg::STARTUP_LSB +: 8] = s.startup_wait;
      end
      cgc_pkg::OFS_MEAS: begin
        rd_val[15:0]                      = s.main_freq_count;
        rd_val[cgc_pkg::MEAS_VALID_BIT]   = s.freq_valid;
      end
      cgc_pkg::OFS_PLL: begin
        rd_val[cgc_pkg::PLL_DIV_LSB +: 8]   = s.pll_div;
        rd_val[cgc_pkg::LOCK_WAIT_LSB +: 6] = s.lock_wait;
        rd_val[cgc_pkg::RANGE_LSB +: 2]     = s.out_range;
        rd_val[cgc_pkg::FACTOR_LSB +: 11]   = s.pll_factor;
        rd_val[cgc_pkg::USB_LSB +: 2]       = s.usb_ratio;
      end
      cgc_pkg::OFS_SYS:  rd_val[cgc_pkg::SEL_LSB +: 5] = s.sys_sel;
      cgc_pkg::OFS_PCK0: rd_val[cgc_pkg::SEL_LSB +: 5] = s.pck_sel[0];
      cgc_pkg::OFS_PCK1: rd_val[cgc_pkg::SEL_LSB +: 5] = s.pck_sel[1];
      cgc_pkg::OFS_PCK2: rd_val[cgc_pkg::SEL_LSB +: 5] = s.pck_sel[2];
      cgc_pkg::OFS_STAT: rd_val = status;
      default:           rd_val = '0;
    endcase
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_s             = s;
    next_s.wr_pend     = 1'b0;
    next_s.pll_in_tick = 1'b0;
    next_s.usb_tick    = 1'b0;
    next_s.rdy         = 1'b1;
    if (accept) begin
      next_s.addr_q  = haddr[7:0];
      next_s.wr_pend = hwrite;
      next_s.rdata   = hwrite ? 32'h00000000 : rd_val;
    end

    if (wr_osc) begin
      next_s.osc_on       = hwdata[cgc_pkg::OSC_ON_BIT];
      next_s.ext_mode     = hwdata[cgc_pkg::EXT_MODE_BIT];
      next_s.startup_wait = hwdata[cgc_pkg::STARTUP_LSB +: 8];
    end
    if (next_s.ext_mode) begin
      next_s.stable = 1'b1;
    end
    // startup wait of field times eight slow ticks
    unique case (s.ost)
      cgc_pkg::OSC_OFF: begin
        if (next_s.osc_on && !next_s.ext_mode) begin
          next_s.ost     = cgc_pkg::OSC_START;
          next_s.osc_cnt = 11'(next_s.startup_wait) << cgc_pkg::STARTUP_SHIFT;
        end
      end
      cgc_pkg::OSC_START: begin
        if (!next_s.osc_on) begin
          next_s.ost = cgc_pkg::OSC_OFF;
        end else if (s.osc_cnt == 11'h000) begin
          next_s.ost    = cgc_pkg::OSC_STABLE;
          next_s.stable = 1'b1;
        end else if (slow_clk_tick) begin
          next_s.osc_cnt = s.osc_cnt - 11'h001;
        end
      end
      cgc_pkg::OSC_STABLE: begin
        if (!next_s.osc_on) begin
          next_s.ost = cgc_pkg::OSC_OFF;
        end
      end
    endcase

    // count main ticks over sixteen slow periods
    unique case (s.mst)
      cgc_pkg::MEAS_IDLE: begin
        if (s.stable && slow_clk_tick) begin
          next_s.mst     = cgc_pkg::MEAS_RUN;
          next_s.win_cnt = '0;
          next_s.mcnt    = '0;
        end
      end
      cgc_pkg::MEAS_RUN: begin
        if (main_tick && s.mcnt != 16'hFFFF) begin
          next_s.mcnt = s.mcnt + 16'h0001;   // saturates on overrange
        end
        if (slow_clk_tick) begin
          if (s.win_cnt == cgc_pkg::MEAS_LAST) begin
            next_s.main_freq_count = next_s.mcnt;
            next_s.freq_valid      = 1'b1;   // count available
            next_s.mst             = cgc_pkg::MEAS_DONE;
          end else begin
            next_s.win_cnt = s.win_cnt + 5'h01;
          end
        end
      end
      cgc_pkg::MEAS_DONE: next_s.mst = cgc_pkg::MEAS_DONE;
    endcase

    // stable and valid drop only with both bits clear
    if (!next_s.osc_on && !next_s.ext_mode) begin
      next_s.stable     = 1'b0;
      next_s.freq_valid = 1'b0;
      next_s.mst        = cgc_pkg::MEAS_IDLE;
    end

    // pll write restarts the lock countdown
    if (wr_pll) begin
      next_s.pll_div    = hwdata[cgc_pkg::PLL_DIV_LSB +: 8];
      next_s.lock_wait  = hwdata[cgc_pkg::LOCK_WAIT_LSB +: 6];
      next_s.out_range  = hwdata[cgc_pkg::RANGE_LSB +: 2];
      next_s.pll_factor = hwdata[cgc_pkg::FACTOR_LSB +: 11];
      next_s.usb_ratio  = hwdata[cgc_pkg::USB_LSB +: 2];
      next_s.lock_cnt   = hwdata[cgc_pkg::LOCK_WAIT_LSB +: 6];
      next_s.locked     = 1'b0;
      next_s.div_cnt    = '0;
      next_s.usb_cnt    = '0;
    end else if (!s.locked) begin
      // lock after the programmed slow ticks
      if (s.lock_cnt == 6'h00) begin
        next_s.locked = 1'b1;
      end else if (slow_clk_tick) begin
        next_s.lock_cnt = s.lock_cnt - 6'h01;
      end
    end

    if (!wr_pll && main_tick && s.pll_div != 8'h00) begin
      if (s.div_cnt >= s.pll_div - 8'h01) begin
        next_s.div_cnt     = '0;
        next_s.pll_in_tick = 1'b1;
      end else begin
        next_s.div_cnt = s.div_cnt + 8'h01;
      end
    end

    // usb divider, reserved code stays silent
    if (!wr_pll && pll_tick && s.usb_ratio != cgc_pkg::USB_RSVD) begin
      if (s.usb_cnt >= usb_lim) begin
        next_s.usb_cnt  = '0;
        next_s.usb_tick = 1'b1;
      end else begin
        next_s.usb_cnt = s.usb_cnt + 2'h1;
      end
    end

    if (wr_sys) begin
      next_s.sys_sel = hwdata[cgc_pkg::SEL_LSB +: 5];
    end
    for (int i = 0; i < NUM_PROG; i++) begin
      if (wr_pck[i]) begin
        next_s.pck_sel[i] = hwdata[cgc_pkg::SEL_LSB +: 5];
      end
    end

    if (wr_ien) begin
      next_s.irq_en = s.irq_en | (hwdata & cgc_pkg::IRQ_BITS);
    end
    if (wr_idis) begin
      next_s.irq_en = s.irq_en & ~(hwdata & cgc_pkg::IRQ_BITS);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= S_RST;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // prescalers
  // ****************************************************************
  // master clock prescaler, ready at reset
  cgc_prescaler #(.READY_INIT(1'b1)) u_sys (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .sel       (s.sys_sel),
    .restart   (wr_sys),
    .slow_tick (slow_clk_tick),
    .main_tick (main_tick),
    .pll_tick  (pll_tick),
    .out_tick  (sys_clk_tick),
    .ready     (sys_rdy)
  );

  for (genvar g = 0; g < NUM_PROG; g++) begin : g_pck
    cgc_prescaler #(.READY_INIT(1'b0)) u_pck (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .sel       (s.pck_sel[g]),
      .restart   (wr_pck[g]),
      .slow_tick (slow_clk_tick),
      .main_tick (main_tick),
      .pll_tick  (pll_tick),
      .out_tick  (prog_clock_out[g]),
      .ready     (pck_rdy[g])
    );
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign hreadyout      = s.rdy;
  assign hresp          = 1'b0 & s.rdy;   // always OKAY
  assign hrdata         = s.rdata;
  assign osc_enable     = s.osc_on;
  assign pll_in_tick    = s.pll_in_tick;
  assign pll_factor_out = s.pll_factor;
  assign pll_range      = s.out_range;
  assign usb_clk_tick   = s.usb_tick;
  assign irq_enabled    = s.irq_en;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  bypass_stable_a : assert property (s.ext_mode |-> s.stable)
    else $error("bypass mode without stable flag");
  stable_clear_a : assert property ($fell(s.stable) |-> !s.osc_on && !s.ext_mode)
    else $error("stable flag dropped while a source bit is set");
  startup_end_a : assert property (s.ost == cgc_pkg::OSC_START && s.osc_on
    && s.osc_cnt == 11'h000 && !wr_osc |=> s.stable)
    else $error("stable not set at end of startup wait");
  valid_off_a : assert property (!s.osc_on && !s.ext_mode |-> !s.freq_valid)
    else $error("measurement valid while oscillator disabled");
  pll_write_a : assert property (wr_pll |=> !s.locked
    && s.lock_cnt == $past(hwdata[cgc_pkg::LOCK_WAIT_LSB +: 6]))
    else $error("pll write did not restart lock countdown");
  lock_set_a : assert property (!s.locked && s.lock_cnt == 6'h00 && !wr_pll |=> s.locked)
    else $error("lock not set when countdown reached zero");
  div_zero_a : assert property (s.pll_div == 8'h00 |=> !s.pll_in_tick)
    else $error("pll divider produced output with zero ratio");
  factor_zero_a : assert property (s.pll_factor == 11'h000 |=> !s.usb_tick)
    else $error("usb clock runs with pll deactivated");
  irq_set_a : assert property (wr_ien |=> (s.irq_en & $past(hwdata) & cgc_pkg::IRQ_BITS)
    == ($past(hwdata) & cgc_pkg::IRQ_BITS))
    else $error("enable write did not set interrupt bits");
  irq_clr_a : assert property (wr_idis |=> (s.irq_en & $past(hwdata)) == 32'h00000000)
    else $error("disable write did not clear interrupt bits");

  startup_done_c : cover property ($rose(s.stable) && !s.ext_mode);
  lock_seen_c    : cover property ($rose(s.locked));
  meas_done_c    : cover property ($rose(s.freq_valid));
  prog_tick_c    : cover property (prog_clock_out[0]);

endmodule

// ==== cgc_pkg.sv ====
// constants, register map and state enumerations of the clock generator control block
// assumes an AHB-Lite slave decode on the low address byte and 32-bit data
// How it works
// - bypass mode uses pin clock, sets stable
// - stable clears only when both bits clear
// - startup waits field times 8 slow ticks
// - count main ticks over 16 slow periods
// - valid bit low when disabled, high after count
// - input ratio: 0 off, 1 bypass, else divide
// - lock set after lock_wait slow ticks
// - factor zero disables the pll
// - usb ratio: 1, 2, 4, 11 reserved
// - source: slow, main, reserved, pll
// - prescaler divides by power of two up to 64
// - each programmable clock has own selects
// - enable register sets bits on ones
// - disable register clears bits on ones
// - status bit 0 shows oscillator stable
// - status bit 2 shows pll locked
// - oscillator enable starts the startup wait when bypass mode is off
// - ready bits show prescaled clocks ready
package cgc_pkg;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_OSC   = 8'h20;
  localparam logic [7:0] OFS_MEAS  = 8'h24;
  localparam logic [7:0] OFS_PLL   = 8'h2C;
  localparam logic [7:0] OFS_SYS   = 8'h30;
  localparam logic [7:0] OFS_PCK0  = 8'h40;
  localparam logic [7:0] OFS_PCK1  = 8'h44;
  localparam logic [7:0] OFS_PCK2  = 8'h48;
  localparam logic [7:0] OFS_IEN   = 8'h60;
  localparam logic [7:0] OFS_IDIS  = 8'h64;
  localparam logic [7:0] OFS_STAT  = 8'h68;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int OSC_ON_BIT    = 0;
  localparam int EXT_MODE_BIT  = 1;
  localparam int STARTUP_LSB   = 8;
  localparam int MEAS_VALID_BIT = 16;
  localparam int PLL_DIV_LSB   = 0;
  localparam int LOCK_WAIT_LSB = 8;
  localparam int RANGE_LSB     = 14;
  localparam int FACTOR_LSB    = 16;
  localparam int USB_LSB       = 28;
  localparam int SEL_LSB       = 0;
  localparam int ST_STABLE     = 0;
  localparam int ST_LOCK       = 2;
  localparam int ST_SYS_RDY    = 3;
  localparam int ST_PCK_LSB    = 8;

  // ****************************************************************
  // reset values, masks and timing
  // ****************************************************************
  localparam logic [5:0]  LOCK_WAIT_RST  = 6'h3F;
  localparam logic [31:0] IRQ_BITS       = 32'h0000070D;
  localparam int          STARTUP_SHIFT  = 3;   // times eight slow ticks
  localparam logic [4:0]  MEAS_LAST      = 5'h0F; // window of sixteen periods
  localparam logic [1:0]  SRC_SLOW       = 2'h0;
  localparam logic [1:0]  SRC_MAIN       = 2'h1;
  localparam logic [1:0]  SRC_PLL        = 2'h3;
  localparam logic [2:0]  CLOCK_DIVIDE_SELECT_RSVD      = 3'h7;
  localparam logic [1:0]  USB_RSVD       = 2'h3;

  typedef enum logic [1:0] {OSC_OFF, OSC_START, OSC_STABLE} cgc_osc_t;
  typedef enum logic [1:0] {MEAS_IDLE, MEAS_RUN, MEAS_DONE} cgc_meas_t;

endpackage

// ==== cgc_prescaler.sv ====
// one clock source selector with power-of-two prescaler and ready flag
// assumes every source clock arrives as a one-cycle enable on hclk
`timescale 1ns/1ps
module cgc_prescaler #(
  parameter logic READY_INIT = 1'b0
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [4:0] sel,
  input  wire logic       restart,
  input  wire logic       slow_tick,
  input  wire logic       main_tick,
  input  wire logic       pll_tick,
  output logic            out_tick,
  output logic            ready
);

  typedef struct packed {
    logic [5:0] cnt;
    logic       tick;
    logic       ready;
  } cgc_pre_t;

  cgc_pre_t   s;
  cgc_pre_t   next_s;
  logic [1:0] src;
  logic [2:0] clock_divide_select;
  logic [5:0] limit;
  logic       src_tick;

  // ****************************************************************
  // source choice and divider
  // ****************************************************************
  assign src   = sel[1:0];
  assign clock_divide_select  = sel[4:2];
  assign limit = 6'((7'h01 << clock_divide_select) - 7'h01);

  always_comb begin
    unique case (src)
      cgc_pkg::SRC_SLOW: src_tick = slow_tick;
      cgc_pkg::SRC_MAIN: src_tick = main_tick;
      cgc_pkg::SRC_PLL:  src_tick = pll_tick;
      default:           src_tick = 1'b0;   // reserved source stays silent
    endcase
  end

  always_comb begin
    next_s      = s;
    next_s.tick = 1'b0;
    if (restart) begin
      next_s.cnt   = '0;
      next_s.ready = 1'b0;
    end else if (src_tick && clock_divide_select != cgc_pkg::CLOCK_DIVIDE_SELECT_RSVD) begin
      if (s.cnt >= limit) begin
        next_s.cnt   = '0;
        next_s.tick  = 1'b1;
        next_s.ready = 1'b1;   // ready after first edge
      end else begin
        next_s.cnt = s.cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '{cnt: 6'h00, tick: 1'b0, ready: READY_INIT};
    end else begin
      s <= next_s;
    end
  end

  assign out_tick = s.tick;
  assign ready    = s.ready;

  // ****************************************************************
  // checks
  // ****************************************************************
  reserved_silent_a : assert property (@(posedge hclk) disable iff (!hresetn)
    clock_divide_select == cgc_pkg::CLOCK_DIVIDE_SELECT_RSVD && !restart |=> !s.tick)
    else $error("reserved prescaler code produced a tick");
  restart_ready_a : assert property (@(posedge hclk) disable iff (!hresetn)
    restart |=> !s.ready && !s.tick)
    else $error("ready not cleared by a selection write");

endmodule

// ==== tb_top.sv ====
// self-checking bench for the clock generator control block
// assumes one ahb-lite slave whose hreadyout is also the bus hready
`timescale 1ns/1ps
module tb_top;
  logic        hclk           = 1'b0;
  logic        hresetn        = 1'b0;
  logic        hsel           = 1'b0;
  logic [31:0] haddr          = 32'h0;
  logic [1:0]  htrans         = 2'h0;
  logic        hwrite         = 1'b0;
  logic [2:0]  hsize          = 3'h2;
  logic [31:0] hwdata         = 32'h0;
  logic        slow_clk_tick  = 1'b0;
  logic        osc_clk_tick   = 1'b0;
  logic        crystal_in_pin = 1'b0;
  logic        pll_clk_tick   = 1'b0;
  logic [7:0]  tick_cnt       = 8'h0;
  wire         hready;
  wire  [31:0] hrdata;
  wire         osc_enable;
  wire  [10:0] pll_factor_out;
  wire         sys_clk_tick;
  wire  [2:0]  prog_clock_out;
  wire  [31:0] irq_enabled;
  wire         hresp;
  wire  [1:0]  pll_range;
  wire         pll_in_tick;
  wire         usb_clk_tick;
  int          errors          = 0;
  int          samples_checked = 0;
  logic [31:0] rd;

  always #2.5 hclk = ~hclk;

  // ****************************************************************
  // source ticks: slow every 16 cycles, crystal and osc every 4, pll every 2
  // ****************************************************************
  always @(posedge hclk) begin
    tick_cnt       <= tick_cnt + 8'h01;
    slow_clk_tick  <= (tick_cnt[3:0] == 4'h0);
    osc_clk_tick   <= (tick_cnt[1:0] == 2'h1);
    crystal_in_pin <= (tick_cnt[1:0] == 2'h2);
    pll_clk_tick   <= tick_cnt[0];
  end

  cgc_clock_ctrl i_cgc_clock_ctrl (
    .hclk           (hclk),
    .hresetn        (hresetn),
    .hsel           (hsel),
    .haddr          (haddr),
    .htrans         (htrans),
    .hwrite         (hwrite),
    .hsize          (hsize),
    .hwdata         (hwdata),
    .hready         (hready),
    .hreadyout      (hready),
    .hresp          (hresp),
    .hrdata         (hrdata),
    .slow_clk_tick  (slow_clk_tick),
    .osc_clk_tick   (osc_clk_tick),
    .crystal_in_pin (crystal_in_pin),
    .pll_clk_tick   (pll_clk_tick),
    .osc_enable     (osc_enable),
    .pll_in_tick    (pll_in_tick),
    .pll_factor_out (pll_factor_out),
    .pll_range      (pll_range),
    .usb_clk_tick   (usb_clk_tick),
    .sys_clk_tick   (sys_clk_tick),
    .prog_clock_out (prog_clock_out),
    .irq_enabled    (irq_enabled)
  );

  // ****************************************************************
  // bus and compare helpers
  // ****************************************************************
  // range compare; an unknown never counts as inside
  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    samples_checked++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      errors++;
      $display("ERROR %0t got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask

  // single word transfer; holds each phase until hready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd & m, e, e);
  endtask

  // counts sys, prog 0 and prog 1 ticks over n cycles
  task automatic count(input int n, output int ns, output int n0, output int n1);
    ns = 0;
    n0 = 0;
    n1 = 0;
    repeat (n) begin
      @(posedge hclk);
      if (sys_clk_tick === 1'b1) ns++;
      if (prog_clock_out[0] === 1'b1) n0++;
      if (prog_clock_out[1] === 1'b1) n1++;
    end
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    rchk(cgc_pkg::OFS_STAT, 32'hFFFFFFFF, 32'h8);
    chk({31'h0, hresp}, 32'h0, 32'h0);
    rchk(cgc_pkg::OFS_PLL, 32'hFFFFFFFF, 32'h3F00);
    xfer(1'b1, cgc_pkg::OFS_MEAS, 32'hFFFFFFFF);
    rchk(cgc_pkg::OFS_MEAS, 32'hFFFFFFFF, 32'h0);
    rchk(8'h28, 32'hFFFFFFFF, 32'h0);
  endtask

  // bypass sets stable; count 64 crystal ticks per 16 slow periods
  task automatic t_bypass;
    xfer(1'b1, cgc_pkg::OFS_OSC, 32'h2);
    rchk(cgc_pkg::OFS_STAT, 32'h1, 32'h1);
    repeat (700) @(posedge hclk);
    rchk(cgc_pkg::OFS_MEAS, 32'h1FFFF, 32'h10040);
    chk({31'h0, osc_enable}, 32'h0, 32'h0);
    xfer(1'b1, cgc_pkg::OFS_OSC, 32'h0);
    rchk(cgc_pkg::OFS_STAT, 32'h1, 32'h0);
    rchk(cgc_pkg::OFS_MEAS, 32'h10000, 32'h0);
  endtask

  // startup of 2 gives 16 slow ticks before stable
  task automatic t_startup;
    xfer(1'b1, cgc_pkg::OFS_OSC, 32'h0201);
    repeat (200) @(posedge hclk);
    chk({31'h0, osc_enable}, 32'h1, 32'h1);
    rchk(cgc_pkg::OFS_STAT, 32'h1, 32'h0);
    repeat (100) @(posedge hclk);
    rchk(cgc_pkg::OFS_STAT, 32'h1, 32'h1);
    repeat (700) @(posedge hclk);
    rchk(cgc_pkg::OFS_MEAS, 32'h1FFFF, 32'h10040);
  endtask

  // lock after 3 slow ticks; a rewrite drops it again
  task automatic t_pll;
    int np;
    int nu;
    np = 0;
    nu = 0;
    xfer(1'b1, cgc_pkg::OFS_PLL, 32'h00010301);
    rchk(cgc_pkg::OFS_STAT, 32'h4, 32'h0);
    chk({21'h0, pll_factor_out}, 32'h1, 32'h1);
    // ratio 1 passes each main tick, usb code 00 each pll tick
    repeat (64) begin
      @(posedge hclk);
      if (pll_in_tick === 1'b1) np++;
      if (usb_clk_tick === 1'b1) nu++;
    end
    chk(np, 32'd15, 32'd17);
    chk(nu, 32'd31, 32'd33);
    rchk(cgc_pkg::OFS_STAT, 32'h4, 32'h4);
    xfer(1'b1, cgc_pkg::OFS_PLL, 32'h00018301);
    rchk(cgc_pkg::OFS_STAT, 32'h4, 32'h0);
    rchk(cgc_pkg::OFS_PLL, 32'hFFFFFFFF, 32'h00018301);
    chk({30'h0, pll_range}, 32'h2, 32'h2);
  endtask

  task automatic t_irq;
    xfer(1'b1, cgc_pkg::OFS_IEN, 32'hFFFFFFFF);
    xfer(1'b1, cgc_pkg::OFS_IEN, 32'h0);
    chk(irq_enabled, 32'h70D, 32'h70D);
    xfer(1'b1, cgc_pkg::OFS_IDIS, 32'h4);
    xfer(1'b1, cgc_pkg::OFS_IDIS, 32'h0);
    chk(irq_enabled, 32'h709, 32'h709);
    rchk(cgc_pkg::OFS_IEN, 32'hFFFFFFFF, 32'h0);
  endtask

  // every prescaler code on the slow source, sys and prog 0 alike
  task automatic t_presc;
    int ns, n0, n1;
    logic [31:0] e;
    for (int p = 0; p < 8; p++) begin
      xfer(1'b1, cgc_pkg::OFS_SYS, 32'(p) << 2);
      xfer(1'b1, cgc_pkg::OFS_PCK0, 32'(p) << 2);
      repeat (40) @(posedge hclk);
      count(2048, ns, n0, n1);
      e = (p == 7) ? 32'h0 : (32'd128 >> p);
      chk(ns, e - (e != 0), e + (e != 0));
      chk(n0, e - (e != 0), e + (e != 0));
      rchk(cgc_pkg::OFS_STAT, 32'h108, (p == 7) ? 32'h0 : 32'h108);
    end
  endtask

  // every source code on prog 1 with the crystal bypassed
  task automatic t_source;
    int ns, n0, n1;
    logic [31:0] e;
    xfer(1'b1, cgc_pkg::OFS_OSC, 32'h2);
    for (int s = 0; s < 4; s++) begin
      xfer(1'b1, cgc_pkg::OFS_PCK1, 32'(s));
      repeat (40) @(posedge hclk);
      count(256, ns, n0, n1);
      e = (s == 0) ? 32'd16 : (s == 1) ? 32'd64 : (s == 3) ? 32'd128 : 32'h0;
      chk(n1, e - (e != 0), e + (e != 0));
    end
  endtask

  task automatic print_verdict;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_bypass();
    t_startup();
    t_pll();
    t_irq();
    t_presc();
    t_source();
    print_verdict();
  end

  // run needs about 20k cycles; three times that means a hang
  initial begin
    repeat (60000) @(posedge hclk);
    errors++;
    $display("ERROR %0t watchdog expired", $time);
    print_verdict();
  end
endmodule
